// ==== design/synth1_divider_config_regs.sv ====
`timescale 1ns/1ps
// Register bank for the first fractional-N synthesizer: doubler, pump,
// integer divider, fractional numerator/denominator and modulator control.
// Assumes an APB master on clk_i and an asynchronous active-low reset.
//
// Function
// [RULE1] Doubler enabled when control bit four set
// [RULE2] Pump code 1-7 is 0.4mA steps, 8 max
// [RULE3] Divider codes 0,1 give ratio one
// [RULE4] Divider built from high nibble, low byte
// [RULE5] Divider resets to 0x066, ratio 102
// [RULE6] Numerator from top six, mid, bottom bytes
// [RULE7] Denominator from top six, mid, bottom bytes
// [RULE8] Numerator and denominator bytes reset zero
// [RULE9] Dither field: weak, medium, strong, off
// [RULE10] Order field: integer, first, second, third
// [RULE11] Reserved bits read zero, ignore writes; the code keeps reserved pump bit 5 writable and it reads back as written
module synth1_divider_config_regs
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [11:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    output logic                         primary_ref_doubler_enable_o,
    output logic      [3:0]              synth1_pump_current_sel_o,
    output logic      [7:0]              synth1_pump_thermo_o,
    output logic                         synth1_pump_boost_o,
    output logic      [11:0]             synth1_integer_divider_o,
    output logic      [11:0]             synth1_divide_ratio_o,
    output logic      [21:0]             synth1_frac_numerator_o,
    output logic      [21:0]             synth1_frac_denominator_o,
    output synth1_cfg_pkg::dither_t      synth1_dither_select_o,
    output synth1_cfg_pkg::order_t       synth1_modulator_order_o
);

    // All state of the bank: the ten stored registers, the read data and the error flag.
    typedef struct packed {
        logic [7:0]  pump_ctrl;      // Doubler, reserved RW bit and pump code.
        logic [7:0]  int_high;       // Divider bits 11..8 in the low nibble.
        logic [7:0]  int_low;        // Divider bits 7..0.
        logic [7:0]  num_top;        // Numerator bits 21..16 in bits 5..0.
        logic [7:0]  num_mid;        // Numerator bits 15..8.
        logic [7:0]  num_bot;        // Numerator bits 7..0.
        logic [7:0]  den_top;        // Denominator bits 21..16 in bits 5..0.
        logic [7:0]  den_mid;        // Denominator bits 15..8.
        logic [7:0]  den_bot;        // Denominator bits 7..0.
        logic [7:0]  mod_ctrl;       // Dither and order fields.
        logic [31:0] rdata;          // Registered read data.
        logic        err;            // Registered slave error.
    } state_t;

    state_t state_q;                 // Registered state.
    state_t state_d;                 // Next state.

    logic       access;              // APB access phase this cycle.
    logic [9:0] word_idx;            // Word index of the address.
    logic       hit;                 // Address maps to a register.
    logic [7:0] rd_byte;             // Selected register value.

    // Tells whether a word address falls inside the register index range.
    function automatic logic is_mapped(input logic [9:0] idx);
        return (idx >= 10'(synth1_cfg_pkg::IDX_PUMP_AND_DOUBLER_CTRL))
            && (idx <= 10'(synth1_cfg_pkg::IDX_MODULATOR_CTRL));
    endfunction

    // Merges the write byte into a register through its writable-bit mask.
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction

    // The slave answers every transfer in its first access cycle, no waits.
    assign access   = psel_i && penable_i;
    assign word_idx = paddr_i[11:2];
    assign hit      = is_mapped(word_idx) && (paddr_i[1:0] == 2'b00);

    // Read mux: stored values already hold zero in reserved bits, except the reserved RW bit 5 of the pump register.
    always_comb
    begin
        unique case (word_idx[7:0])
            synth1_cfg_pkg::IDX_PUMP_AND_DOUBLER_CTRL: rd_byte = state_q.pump_ctrl;
            synth1_cfg_pkg::IDX_INT_DIVIDER_HIGH:      rd_byte = state_q.int_high;
            synth1_cfg_pkg::IDX_INT_DIVIDER_LOW:       rd_byte = state_q.int_low;
            synth1_cfg_pkg::IDX_NUMERATOR_TOP:         rd_byte = state_q.num_top;
            synth1_cfg_pkg::IDX_NUMERATOR_MID:         rd_byte = state_q.num_mid;
            synth1_cfg_pkg::IDX_NUMERATOR_BOTTOM:      rd_byte = state_q.num_bot;
            synth1_cfg_pkg::IDX_DENOMINATOR_TOP:       rd_byte = state_q.den_top;
            synth1_cfg_pkg::IDX_DENOMINATOR_MID:       rd_byte = state_q.den_mid;
            synth1_cfg_pkg::IDX_DENOMINATOR_BOTTOM:    rd_byte = state_q.den_bot;
            synth1_cfg_pkg::IDX_MODULATOR_CTRL:        rd_byte = state_q.mod_ctrl;
            default:                                   rd_byte = 8'h00;
        endcase
    end

    // Next-state logic: writes land at the access edge, reads are sampled at the setup edge.
    always_comb
    begin
        state_d       = state_q;
        state_d.err   = 1'b0;
        state_d.rdata = 32'h0000_0000;
        // Setup phase: latch the answer so it is valid during the access cycle.
        if (psel_i && !penable_i)
        begin
            state_d.err = !hit;
            if (hit && !pwrite_i)
            begin
                state_d.rdata = {24'h00_0000, rd_byte};
            end
        end
        else if (access)
        begin
            // Hold the answer through the access cycle.
            state_d.err   = state_q.err;
            state_d.rdata = state_q.rdata;
        end
        // Only byte lane zero carries data; other lanes hold nothing.
        if (access && pwrite_i && hit && pstrb_i[0])
        begin
            // [RULE11] reserved bits masked
            unique case (word_idx[7:0])
                synth1_cfg_pkg::IDX_PUMP_AND_DOUBLER_CTRL:
                    state_d.pump_ctrl = merge(state_q.pump_ctrl, pwdata_i[7:0],
                                              synth1_cfg_pkg::MASK_PUMP_CTRL);
                synth1_cfg_pkg::IDX_INT_DIVIDER_HIGH:
                    state_d.int_high = merge(state_q.int_high, pwdata_i[7:0],
                                             synth1_cfg_pkg::MASK_NIBBLE);
                synth1_cfg_pkg::IDX_INT_DIVIDER_LOW:
                    state_d.int_low = merge(state_q.int_low, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_BYTE);
                synth1_cfg_pkg::IDX_NUMERATOR_TOP:
                    state_d.num_top = merge(state_q.num_top, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_SIX);
                synth1_cfg_pkg::IDX_NUMERATOR_MID:
                    state_d.num_mid = merge(state_q.num_mid, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_BYTE);
                synth1_cfg_pkg::IDX_NUMERATOR_BOTTOM:
                    state_d.num_bot = merge(state_q.num_bot, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_BYTE);
                synth1_cfg_pkg::IDX_DENOMINATOR_TOP:
                    state_d.den_top = merge(state_q.den_top, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_SIX);
                synth1_cfg_pkg::IDX_DENOMINATOR_MID:
                    state_d.den_mid = merge(state_q.den_mid, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_BYTE);
                synth1_cfg_pkg::IDX_DENOMINATOR_BOTTOM:
                    state_d.den_bot = merge(state_q.den_bot, pwdata_i[7:0],
                                            synth1_cfg_pkg::MASK_BYTE);
                synth1_cfg_pkg::IDX_MODULATOR_CTRL:
                    state_d.mod_ctrl = merge(state_q.mod_ctrl, pwdata_i[7:0],
                                             synth1_cfg_pkg::MASK_NIBBLE);
                default:
                    state_d.mod_ctrl = state_q.mod_ctrl;
            endcase
        end
    end

    // State register with documented reset values.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            // [RULE1] doubler resets on
            state_q.pump_ctrl <= synth1_cfg_pkg::RST_PUMP_CTRL;
            // [RULE5] divider reset value
            state_q.int_high  <= synth1_cfg_pkg::RST_INT_HIGH;
            state_q.int_low   <= synth1_cfg_pkg::RST_INT_LOW;
            // [RULE8] fractional bytes zero
            state_q.num_top   <= synth1_cfg_pkg::RST_FRAC;
            state_q.num_mid   <= synth1_cfg_pkg::RST_FRAC;
            state_q.num_bot   <= synth1_cfg_pkg::RST_FRAC;
            state_q.den_top   <= synth1_cfg_pkg::RST_FRAC;
            state_q.den_mid   <= synth1_cfg_pkg::RST_FRAC;
            state_q.den_bot   <= synth1_cfg_pkg::RST_FRAC;
            state_q.mod_ctrl  <= synth1_cfg_pkg::RST_MOD_CTRL;
            state_q.rdata     <= 32'h0000_0000;
            state_q.err       <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Bus answers: zero wait states, error on unmapped or misaligned addresses.
    assign pready_o  = 1'b1;
    assign pslverr_o = access && state_q.err;
    assign prdata_o  = state_q.rdata;

    // [RULE1] doubler enable bit
    assign primary_ref_doubler_enable_o = state_q.pump_ctrl[synth1_cfg_pkg::DOUBLER_BIT];
    assign synth1_pump_current_sel_o    = state_q.pump_ctrl[synth1_cfg_pkg::PUMP_LSB +: 4];
    // [RULE4] divider assembly
    assign synth1_integer_divider_o     = {state_q.int_high[3:0], state_q.int_low};
    // [RULE6] numerator assembly
    assign synth1_frac_numerator_o      = {state_q.num_top[5:0], state_q.num_mid,
                                           state_q.num_bot};
    // [RULE7] denominator assembly
    assign synth1_frac_denominator_o    = {state_q.den_top[5:0], state_q.den_mid,
                                           state_q.den_bot};

    // Field decoders feeding the analog controls.
    synth1_field_decode u_decode
    (
        .pump_code_i   (state_q.pump_ctrl[synth1_cfg_pkg::PUMP_LSB +: 4]),
        .div_code_i    (synth1_integer_divider_o),
        .dither_code_i (state_q.mod_ctrl[synth1_cfg_pkg::DITHER_LSB +: 2]),
        .order_code_i  (state_q.mod_ctrl[synth1_cfg_pkg::ORDER_LSB +: 2]),
        .pump_thermo_o (synth1_pump_thermo_o),
        .pump_boost_o  (synth1_pump_boost_o),
        .div_ratio_o   (synth1_divide_ratio_o),
        .dither_mode_o (synth1_dither_select_o),
        .order_mode_o  (synth1_modulator_order_o)
    );

    // Write access to a given index at this edge.
    sequence s_write_to(logic [7:0] idx);
        psel_i && penable_i && pwrite_i && pstrb_i[0] && (paddr_i[1:0] == 2'b00)
            && (paddr_i[11:2] == 10'(idx));
    endsequence

    // Doubler output follows bit four of a write to the control register.
    a_doubler_write: assert property (  // RULE1
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_to(synth1_cfg_pkg::IDX_PUMP_AND_DOUBLER_CTRL) |=>
            primary_ref_doubler_enable_o == $past(pwdata_i[4]))
        else $error("doubler enable does not follow write");

    // Pump boost only at code eight, three legs for code three.
    a_pump_decode: assert property (  // RULE2
        @(posedge clk_i) disable iff (!rst_b_i)
        (synth1_pump_boost_o == (synth1_pump_current_sel_o == 4'h8))
            && ((synth1_pump_current_sel_o == 4'h3) -> (synth1_pump_thermo_o == 8'h07)))
        else $error("pump current decode wrong");

    // Ratio equals code above one, else unity.
    a_div_ratio: assert property (  // RULE3
        @(posedge clk_i) disable iff (!rst_b_i)
        synth1_divide_ratio_o == ((synth1_integer_divider_o < 12'h002) ? 12'h001
                                  : synth1_integer_divider_o))
        else $error("divide ratio wrong");

    // A low-byte write lands in divider bits 7..0 one cycle later.
    a_div_low_write: assert property (  // RULE4
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_to(synth1_cfg_pkg::IDX_INT_DIVIDER_LOW) |=>
            synth1_integer_divider_o[7:0] == $past(pwdata_i[7:0]))
        else $error("divider low byte not written");

    // Divider holds its reset value at the first edge after reset release.
    a_div_reset: assert property (  // RULE5
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> synth1_integer_divider_o == 12'h066)
        else $error("divider reset value wrong");

    // Numerator top write lands in bits 21..16.
    a_num_top_write: assert property (  // RULE6
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_to(synth1_cfg_pkg::IDX_NUMERATOR_TOP) |=>
            synth1_frac_numerator_o[21:16] == $past(pwdata_i[5:0]))
        else $error("numerator top not written");

    // Denominator middle write lands in bits 15..8.
    a_den_mid_write: assert property (  // RULE7
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_to(synth1_cfg_pkg::IDX_DENOMINATOR_MID) |=>
            synth1_frac_denominator_o[15:8] == $past(pwdata_i[7:0]))
        else $error("denominator middle not written");

    // Order and dither outputs track a modulator-control write.
    a_mod_write: assert property (  // RULE10
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_to(synth1_cfg_pkg::IDX_MODULATOR_CTRL) |=>
            (synth1_modulator_order_o == $past(pwdata_i[1:0]))
            && (synth1_dither_select_o == $past(pwdata_i[3:2])))
        else $error("modulator control not written");

    // Reserved high bits of the modulator register never read back as set.
    a_reserved_zero: assert property (  // RULE11
        @(posedge clk_i) disable iff (!rst_b_i)
        state_q.mod_ctrl[7:4] == 4'h0 && state_q.pump_ctrl[7:6] == 2'b00)
        else $error("reserved bits not zero");

endmodule

// ==== design/synth1_cfg_pkg.sv ====
// Constants for the first synthesizer's divider configuration register bank.
// Assumes a 32-bit APB slave where each 8-bit register sits in one aligned word.
package synth1_cfg_pkg;

    // Printed register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PUMP_AND_DOUBLER_CTRL = 8'h39;
    localparam logic [7:0] IDX_INT_DIVIDER_HIGH      = 8'h3A;
    localparam logic [7:0] IDX_INT_DIVIDER_LOW       = 8'h3B;
    localparam logic [7:0] IDX_NUMERATOR_TOP         = 8'h3C;
    localparam logic [7:0] IDX_NUMERATOR_MID         = 8'h3D;
    localparam logic [7:0] IDX_NUMERATOR_BOTTOM      = 8'h3E;
    localparam logic [7:0] IDX_DENOMINATOR_TOP       = 8'h3F;
    localparam logic [7:0] IDX_DENOMINATOR_MID       = 8'h40;
    localparam logic [7:0] IDX_DENOMINATOR_BOTTOM    = 8'h41;
    localparam logic [7:0] IDX_MODULATOR_CTRL        = 8'h42;

    // Writable-bit masks; all other bits are reserved, read zero, ignore writes.
    localparam logic [7:0] MASK_PUMP_CTRL = 8'h3F;
    localparam logic [7:0] MASK_NIBBLE    = 8'h0F;
    localparam logic [7:0] MASK_SIX       = 8'h3F;
    localparam logic [7:0] MASK_BYTE      = 8'hFF;

    // Field positions.
    localparam int DOUBLER_BIT   = 4;
    localparam int PUMP_LSB      = 0;
    localparam int DITHER_LSB    = 2;
    localparam int ORDER_LSB     = 0;

    // Reset values of the registers.
    localparam logic [7:0] RST_PUMP_CTRL = 8'h18;
    localparam logic [7:0] RST_INT_HIGH  = 8'h00;
    localparam logic [7:0] RST_INT_LOW   = 8'h66;
    localparam logic [7:0] RST_FRAC      = 8'h00;
    localparam logic [7:0] RST_MOD_CTRL  = 8'h0C;

    // Pump code that selects the top current, and the smallest real divide ratio.
    localparam logic [3:0]  PUMP_CODE_MAX = 4'h8;
    localparam logic [11:0] DIV_MIN_RATIO = 12'h002;
    localparam logic [11:0] DIV_UNITY     = 12'h001;

    // Dither strength settings.
    typedef enum logic [1:0] {
        DITHER_WEAK     = 2'b00,
        DITHER_MEDIUM   = 2'b01,
        DITHER_STRONG   = 2'b10,
        DITHER_DISABLED = 2'b11
    } dither_t;

    // Modulator order settings.
    typedef enum logic [1:0] {
        ORDER_INTEGER = 2'b00,
        ORDER_FIRST   = 2'b01,
        ORDER_SECOND  = 2'b10,
        ORDER_THIRD   = 2'b11
    } order_t;

endpackage

// ==== design/synth1_field_decode.sv ====
`timescale 1ns/1ps
// Decodes raw synthesizer fields into the forms the analog side consumes.
// Assumes its inputs come straight from registered configuration bits.
module synth1_field_decode
(
    input  wire logic [3:0]              pump_code_i,
    input  wire logic [11:0]             div_code_i,
    input  wire logic [1:0]              dither_code_i,
    input  wire logic [1:0]              order_code_i,
    output logic      [7:0]              pump_thermo_o,
    output logic                         pump_boost_o,
    output logic      [11:0]             div_ratio_o,
    output synth1_cfg_pkg::dither_t      dither_mode_o,
    output synth1_cfg_pkg::order_t       order_mode_o
);

    // Pump decode: codes 1..7 enable that many 0.4 mA legs, code 8 the boost leg.
    // Codes 0 and 9..15 are undocumented; they enable no legs, a safe choice.
    always_comb
    begin
        pump_thermo_o = 8'h00;
        pump_boost_o  = 1'b0;
        // [RULE2] pump current decode
        if (pump_code_i == synth1_cfg_pkg::PUMP_CODE_MAX)
        begin
            pump_boost_o = 1'b1;
        end
        else if (pump_code_i < synth1_cfg_pkg::PUMP_CODE_MAX)
        begin
            pump_thermo_o = 8'((9'h001 << pump_code_i) - 9'h001);
        end
    end

    // Divider codes below two collapse to a unity ratio.
    always_comb
    begin
        // [RULE3] unity ratio clamp
        if (div_code_i < synth1_cfg_pkg::DIV_MIN_RATIO)
        begin
            div_ratio_o = synth1_cfg_pkg::DIV_UNITY;
        end
        else
        begin
            div_ratio_o = div_code_i;
        end
    end

    // [RULE9] dither mode decode
    assign dither_mode_o = synth1_cfg_pkg::dither_t'(dither_code_i);
    // [RULE10] modulator order decode
    assign order_mode_o  = synth1_cfg_pkg::order_t'(order_code_i);

endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the first synthesizer's configuration register bank.
// Assumes a zero-wait APB slave, byte address four times the register index.
`timescale 1ns/1ps
module testbench;
    logic        clk_i;        // 200 MHz bench clock.
    logic        rst_b_i;      // Asynchronous reset, active low.
    logic        psel_i;       // APB select.
    logic        penable_i;    // APB access phase.
    logic        pwrite_i;     // APB direction.
    logic [11:0] paddr_i;      // APB byte address.
    logic [31:0] pwdata_i;     // APB write data.
    logic [3:0]  pstrb_i;      // APB byte strobes.
    logic [31:0] prdata_o;     // APB read data.
    logic        pready_o;     // APB ready.
    logic        pslverr_o;    // APB error.
    logic        dbl_o;        // Doubler enable.
    logic [3:0]  pump_o;       // Pump code.
    logic [7:0]  thermo_o;     // Pump legs.
    logic        boost_o;      // Pump top current.
    logic [11:0] div_o;        // Divider code.
    logic [11:0] ratio_o;      // Effective divide ratio.
    logic [21:0] num_o;        // Fractional numerator.
    logic [21:0] den_o;        // Fractional denominator.
    synth1_cfg_pkg::dither_t dith_o; // Dither strength.
    synth1_cfg_pkg::order_t  ord_o;  // Modulator order.
    int          n_fail;       // Mismatches.
    int          checked;      // Comparisons made.
    logic [31:0] rd;           // Last read data.
    logic        er;           // Last error response.
    logic [7:0]  idx_t [10];   // Register indices in address order.
    logic [7:0]  rst_t [10];   // Reset values of the registers.
    logic [7:0]  msk_t [10];   // Writable bits of the registers.
    synth1_divider_config_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .primary_ref_doubler_enable_o(dbl_o), .synth1_pump_current_sel_o(pump_o),
        .synth1_pump_thermo_o(thermo_o), .synth1_pump_boost_o(boost_o),
        .synth1_integer_divider_o(div_o), .synth1_divide_ratio_o(ratio_o),
        .synth1_frac_numerator_o(num_o), .synth1_frac_denominator_o(den_o),
        .synth1_dither_select_o(dith_o), .synth1_modulator_order_o(ord_o));
    // The clock toggles every half period.
    always #2.5 clk_i = ~clk_i;
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Compares a seen value with an expected one; unknown bits never match.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        pstrb_i <= st;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        // Design flops update in the NBA region, so the answer read here is pre-edge.
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 16);
        if (pready_o !== 1'b1)
        begin
            n_fail++;
            $display("BAD at %0t: transfer never completed", $time);
            summarize();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Let the written value settle before outputs are compared.
        #1;
    endtask
    // Register accesses by index; writes use full strobes, reads none.
    task automatic wr_reg(input logic [7:0] i, input logic [7:0] v);
        bus(1'b1, {2'b00, i, 2'b00}, {24'hFFFFFF, v}, 4'hF);
    endtask
    task automatic rd_reg(input logic [7:0] i, input logic [7:0] exp);
        bus(1'b0, {2'b00, i, 2'b00}, 32'h0, 4'h0);
        chk(rd, {24'h0, exp});
        chk({31'h0, er}, 32'h0);
    endtask
    initial
    begin
        clk_i = 1'b0; rst_b_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
        paddr_i = 12'h000; pwdata_i = 32'h0; pstrb_i = 4'h0; n_fail = 0; checked = 0;
        for (int k = 0; k < 10; k++)
        begin
            idx_t[k] = synth1_cfg_pkg::IDX_PUMP_AND_DOUBLER_CTRL + 8'(k);
            rst_t[k] = 8'h00;
            msk_t[k] = 8'hFF;
        end
        rst_t[0] = 8'h18; rst_t[2] = 8'h66; rst_t[9] = 8'h0C;
        msk_t[0] = 8'h3F; msk_t[1] = 8'h0F; msk_t[3] = 8'h3F; msk_t[6] = 8'h3F;
        msk_t[9] = 8'h0F;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Reset state of the outputs.
        #1;
        chk({31'h0, dbl_o}, 32'h1);
        chk({28'h0, pump_o}, 32'h8);
        chk({20'h0, div_o}, 32'h066);
        chk({20'h0, ratio_o}, 32'h066);
        chk({10'h0, num_o}, 32'h0);
        chk({10'h0, den_o}, 32'h0);
        chk({30'h0, dith_o}, 32'h3);
        chk({30'h0, ord_o}, 32'h0);
        // Reset read-back, then all-ones writes: reserved bits stay zero, except pump bit 5, which reads back set.
        for (int k = 0; k < 10; k++) rd_reg(idx_t[k], rst_t[k]);
        for (int k = 0; k < 10; k++) wr_reg(idx_t[k], 8'hFF);
        for (int k = 0; k < 10; k++) rd_reg(idx_t[k], msk_t[k]);
        // Every pump code, with the doubler on and the reserved bit clear.
        for (int c = 0; c < 16; c++)
        begin
            wr_reg(idx_t[0], 8'h10 | 8'(c));
            chk({31'h0, dbl_o}, 32'h1);
            chk({28'h0, pump_o}, 32'(c));
            chk({24'h0, thermo_o}, (c >= 1 && c <= 7) ? (32'h1 << c) - 1 : 32'h0);
            chk({31'h0, boost_o}, 32'(c == 8));
        end
        wr_reg(idx_t[0], 8'hE8);
        chk({31'h0, dbl_o}, 32'h0);
        rd_reg(idx_t[0], 8'h28);
        // Divider boundary codes, reserved high nibble set on each write.
        for (int j = 0; j < 5; j++)
        begin
            logic [11:0] cd;
            cd = (j == 0) ? 12'h000 : (j == 1) ? 12'h001 : (j == 2) ? 12'h002 :
                 (j == 3) ? 12'hABC : 12'hFFF;
            wr_reg(idx_t[1], 8'hF0 | {4'h0, cd[11:8]});
            wr_reg(idx_t[2], cd[7:0]);
            chk({20'h0, div_o}, {20'h0, cd});
            chk({20'h0, ratio_o}, (cd < 12'h002) ? 32'h1 : {20'h0, cd});
            rd_reg(idx_t[1], {4'h0, cd[11:8]});
        end
        // Numerator and denominator assembly from three bytes each.
        wr_reg(idx_t[3], 8'hFF); wr_reg(idx_t[4], 8'h5A); wr_reg(idx_t[5], 8'hC3);
        wr_reg(idx_t[6], 8'hE5); wr_reg(idx_t[7], 8'h0F); wr_reg(idx_t[8], 8'hF0);
        chk({10'h0, num_o}, 32'h3F5AC3);
        chk({10'h0, den_o}, 32'h250FF0);
        // Every dither and order pair.
        for (int v = 0; v < 16; v++)
        begin
            wr_reg(idx_t[9], 8'hF0 | 8'(v));
            chk({30'h0, dith_o}, 32'(v >> 2));
            chk({30'h0, ord_o}, 32'(v & 3));
        end
        // Unmapped reads and writes, misaligned writes and writes without the lane-zero strobe change nothing.
        bus(1'b1, 12'h0E0, 32'h0, 4'hF);
        chk({31'h0, er}, 32'h1);
        bus(1'b0, 12'h10C, 32'h0, 4'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        bus(1'b1, 12'h0E5, 32'h0, 4'hF);
        chk({31'h0, er}, 32'h1);
        bus(1'b1, 12'h0EC, 32'h11, 4'hE);
        chk({31'h0, er}, 32'h0);
        rd_reg(idx_t[0], 8'h28);
        rd_reg(idx_t[2], 8'hFF);
        summarize();
    end
endmodule
